// [rtl/adc_qseq_map.svh]
// register map, command word fields and conversion timing of the queue sequencer
// assumes: included by the package and the sequencer; APB byte addresses, 32-bit words
`ifndef ADC_QSEQ_MAP_SVH
`define ADC_QSEQ_MAP_SVH

`define ADR_CTRL0       12'h000
`define ADR_Q1_CTL      12'h004
`define ADR_Q2_CTL      12'h008
`define ADR_STATUS      12'h00C
`define CMD_PAGE        4'h1
`define RES_PAGE        4'h2

`define C0_Q2START_LSB  0
`define C0_DIV_LSB      8
`define C0_Q2START_RST  7'h40
`define C0_DIV_RST      8'h0B

`define QC_SWTRIG       0
`define QC_EXTSEL       1
`define QC_CONT         2
`define QC_RESUME       3
`define QC_ARM          4

`define ST_Q1_LSB       0
`define ST_Q2_LSB       4
`define ST_CF_LSB       8
`define ST_PF_LSB       9
`define ST_TOR_LSB      10
`define ST_Q_STEP       4

`define CW_W            10
`define CW_FST_LSB      6
`define CW_BYP          8
`define CW_PAUSE        9
`define END_OF_QUEUE_CODE 6'h3F

`define INIT_CYC        5'h02
`define FINAL_MIN_CYC   5'h02
`define RESOLVE_CYC     5'h0A
`define RES_W           10

`endif

// [rtl/qseq_pkg.sv]
// types shared by the queue sequencer
// assumes: the map header is on the include path
`include "adc_qseq_map.svh"

package qseq_pkg;
    typedef enum logic [2:0] {Q_IDLE, Q_ACTIVE, Q_PAUSED, Q_PENDING, Q_SUSPENDED} qstat_t;
    typedef enum logic {ENG_IDLE, ENG_CONV} eng_t;
    typedef enum logic [1:0] {PH_NONE, PH_BUFFERED, PH_FINAL, PH_RESOLVE} phase_t;
    typedef enum logic [2:0] {SEL_NONE, SEL_CTRL0, SEL_Q1, SEL_Q2, SEL_STAT, SEL_CMD,
                              SEL_RES} sel_t;
endpackage

// [rtl/adc_queue_sequencer.sv]
// two-queue command word sequencer for a successive-approximation converter
// assumes: APB master on i_clk_sys, converter core samples o_conv_* each cycle
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ns
`include "adc_qseq_map.svh"

module adc_queue_sequencer
    import qseq_pkg::*;
(
    // clock and reset
    input  wire logic               i_clk_sys,
    input  wire logic               i_reset,
    // apb slave
    input  wire logic               i_psel,
    input  wire logic               i_penable,
    input  wire logic               i_pwrite,
    input  wire logic [11:0]        i_paddr,
    input  wire logic [31:0]        i_pwdata,
    output logic      [31:0]        o_prdata,
    output logic                    o_pready,
    output logic                    o_pslverr,
    // external trigger pins
    input  wire logic               i_ext_trig_one,
    input  wire logic               i_ext_trig_two,
    // converter core
    output logic                    o_conv_start,
    output logic      [5:0]         o_conv_channel,
    output phase_t                  o_conv_phase,
    input  wire logic [`RES_W-1:0]  i_conv_result
);

    logic [`CW_W-1:0]  cmd_mem [0:63];
    logic [`RES_W-1:0] res_mem [0:63];

    logic [6:0]  q2_start_q;
    logic [7:0]  div_q;
    logic [7:0]  div_cnt_q;
    logic        ext_q   [2];
    logic        cont_q  [2];
    logic        resume_q;
    logic        sw_q    [2];
    logic [2:0]  sync_q  [2];
    logic        lvl_q   [2];
    logic        arm_q   [2];
    qstat_t      st_q    [2];
    logic [6:0]  ptr_q   [2];
    logic        cf_q    [2];
    logic        pf_q    [2];
    logic        tor_q   [2];
    logic [6:0]  sub2_q;
    eng_t        eng_q;
    logic        run_q;
    logic [4:0]  cnt_q;
    logic [`CW_W-1:0] cw_q;

    logic        setup_c;
    logic        wr_c;
    sel_t        sel_c;
    logic [31:0] rd_c;
    logic        tick_c;
    logic        edge_c  [2];
    logic        trig_c  [2];
    logic        abort2_c;
    logic        q_c;
    logic [6:0]  ptr_c;
    logic [6:0]  nptr_c;
    logic [`CW_W-1:0] word_c;
    logic [`CW_W-1:0] nword_c;
    logic        end_c;
    logic        nend_c;
    logic        go_c;
    logic        done_c;

    function automatic sel_t decode(input logic [11:0] a);
        if (a[1:0] != 2'h0) begin
            decode = SEL_NONE;
        end else if (a[11:8] == `CMD_PAGE) begin
            decode = SEL_CMD;
        end else if (a[11:8] == `RES_PAGE) begin
            decode = SEL_RES;
        end else begin
            case (a)
                `ADR_CTRL0:  decode = SEL_CTRL0;
                `ADR_Q1_CTL: decode = SEL_Q1;
                `ADR_Q2_CTL: decode = SEL_Q2;
                `ADR_STATUS: decode = SEL_STAT;
                default:     decode = SEL_NONE;
            endcase
        end
    endfunction

    // end of queue seen at a word position
    function automatic logic is_end(input logic q, input logic [6:0] p,
                                    input logic [`CW_W-1:0] w, input logic [6:0] start2);
        is_end = p[6]
               | (w[5:0] == `END_OF_QUEUE_CODE)
               | (!q && (p == start2));
    endfunction

    function automatic logic [4:0] pre_len(input logic [`CW_W-1:0] w);
        pre_len = w[`CW_BYP] ? 5'h00 : `INIT_CYC;
    endfunction

    function automatic logic [4:0] conv_len(input logic [`CW_W-1:0] w);
        conv_len = pre_len(w) + (`FINAL_MIN_CYC << w[`CW_FST_LSB +: 2])
                 + `RESOLVE_CYC;
    endfunction

    function automatic phase_t phase_of(input logic [`CW_W-1:0] w, input logic [4:0] c);
        if (c < pre_len(w)) begin
            phase_of = PH_BUFFERED;
        end else if (c < pre_len(w) + (`FINAL_MIN_CYC << w[`CW_FST_LSB +: 2])) begin
            phase_of = PH_FINAL;
        end else begin
            phase_of = PH_RESOLVE;
        end
    endfunction

    // apb
    assign setup_c = i_psel & ~i_penable;
    assign wr_c    = i_psel & i_penable & i_pwrite & o_pready;
    assign sel_c   = decode(i_paddr);

    always_comb begin
        rd_c = 32'h0000_0000;
        case (sel_c)
            SEL_CTRL0: begin
                rd_c[`C0_Q2START_LSB +: 7] = q2_start_q;
                rd_c[`C0_DIV_LSB +: 8]     = div_q;
            end
            SEL_Q1, SEL_Q2: begin
                rd_c[`QC_EXTSEL] = ext_q[sel_c == SEL_Q2];
                rd_c[`QC_CONT]   = cont_q[sel_c == SEL_Q2];
                rd_c[`QC_RESUME] = (sel_c == SEL_Q2) & resume_q;
                rd_c[`QC_ARM]    = arm_q[sel_c == SEL_Q2];
            end
            SEL_STAT: begin
                rd_c[`ST_Q1_LSB +: 3] = st_q[0];
                rd_c[`ST_Q2_LSB +: 3] = st_q[1];
                for (int i = 0; i < 2; i++) begin
                    rd_c[`ST_CF_LSB + `ST_Q_STEP * i]  = cf_q[i];
                    rd_c[`ST_PF_LSB + `ST_Q_STEP * i]  = pf_q[i];
                    rd_c[`ST_TOR_LSB + `ST_Q_STEP * i] = tor_q[i];
                end
            end
            SEL_CMD:  rd_c[`CW_W-1:0]  = cmd_mem[i_paddr[7:2]];
            SEL_RES:  rd_c[`RES_W-1:0] = res_mem[i_paddr[7:2]];
            default:  rd_c = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= setup_c;
            if (setup_c) begin
                o_prdata  <= rd_c;
                o_pslverr <= (sel_c == SEL_NONE);
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (wr_c && sel_c == SEL_CMD) begin
            cmd_mem[i_paddr[7:2]] <= i_pwdata[`CW_W-1:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            q2_start_q <= `C0_Q2START_RST;
            div_q      <= `C0_DIV_RST;
        end else if (wr_c && sel_c == SEL_CTRL0) begin
            q2_start_q <= i_pwdata[`C0_Q2START_LSB +: 7];
            div_q      <= i_pwdata[`C0_DIV_LSB +: 8];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            resume_q <= 1'b0;
            for (int i = 0; i < 2; i++) begin
                ext_q[i]  <= 1'b0;
                cont_q[i] <= 1'b0;
                sw_q[i]   <= 1'b0;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                sw_q[i] <= 1'b0;
                if (wr_c && sel_c == (i == 0 ? SEL_Q1 : SEL_Q2)) begin
                    ext_q[i]  <= i_pwdata[`QC_EXTSEL];
                    cont_q[i] <= i_pwdata[`QC_CONT];
                    sw_q[i]   <= i_pwdata[`QC_SWTRIG];
                end
            end
            if (wr_c && sel_c == SEL_Q2) begin
                resume_q <= i_pwdata[`QC_RESUME];
            end
        end
    end

    // conversion clock enable
    assign tick_c = (div_cnt_q == div_q);

    always_ff @(posedge i_clk_sys) begin
        if (i_reset || tick_c) begin
            div_cnt_q <= 8'h00;
        end else begin
            div_cnt_q <= div_cnt_q + 8'h01;
        end
    end

    // trigger pins: three stages, level accepted when stages two and three agree
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            for (int i = 0; i < 2; i++) begin
                sync_q[i] <= 3'h0;
                lvl_q[i]  <= 1'b0;
            end
        end else begin
            sync_q[0] <= {sync_q[0][1:0], i_ext_trig_one};
            sync_q[1] <= {sync_q[1][1:0], i_ext_trig_two};
            for (int i = 0; i < 2; i++) begin
                if (sync_q[i][1] == sync_q[i][2]) begin
                    lvl_q[i] <= sync_q[i][2];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            edge_c[i] = (sync_q[i][1] == sync_q[i][2]) & sync_q[i][2] & ~lvl_q[i];
            trig_c[i] = arm_q[i] & (ext_q[i] ? edge_c[i] : sw_q[i]);
        end
    end

    // sequencing
    assign abort2_c = trig_c[0] & (st_q[1] == Q_ACTIVE);
    assign q_c      = (eng_q == ENG_CONV) ? run_q : (st_q[0] != Q_ACTIVE);
    assign ptr_c    = ptr_q[q_c];
    assign nptr_c   = ptr_c + 7'h01;
    assign word_c   = cmd_mem[ptr_c[5:0]];
    assign nword_c  = cmd_mem[nptr_c[5:0]];
    assign end_c    = is_end(q_c, ptr_c, word_c, q2_start_q);
    assign nend_c   = is_end(q_c, nptr_c, nword_c, q2_start_q);
    assign go_c     = (eng_q == ENG_IDLE) && (st_q[q_c] == Q_ACTIVE) && !(q_c && abort2_c);
    assign done_c   = (eng_q == ENG_CONV) && tick_c && !(run_q && abort2_c)
                      && (cnt_q == 5'(conv_len(cw_q) - 5'h01));

    always_ff @(posedge i_clk_sys) begin
        if (done_c) begin
            res_mem[ptr_c[5:0]] <= i_conv_result;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            eng_q          <= ENG_IDLE;
            run_q          <= 1'b0;
            cnt_q          <= 5'h00;
            cw_q           <= '0;
            sub2_q         <= 7'h00;
            o_conv_start   <= 1'b0;
            o_conv_channel <= 6'h00;
            o_conv_phase   <= PH_NONE;
            for (int i = 0; i < 2; i++) begin
                st_q[i]  <= Q_IDLE;
                ptr_q[i] <= 7'h00;
                arm_q[i] <= 1'b0;
                cf_q[i]  <= 1'b0;
                pf_q[i]  <= 1'b0;
                tor_q[i] <= 1'b0;
            end
        end else begin
            o_conv_start <= 1'b0;
            // software clears first so that a same-cycle set wins
            for (int i = 0; i < 2; i++) begin
                if (wr_c && sel_c == SEL_STAT) begin
                    cf_q[i]  <= cf_q[i] & ~i_pwdata[`ST_CF_LSB + `ST_Q_STEP * i];
                    pf_q[i]  <= pf_q[i] & ~i_pwdata[`ST_PF_LSB + `ST_Q_STEP * i];
                    tor_q[i] <= tor_q[i] & ~i_pwdata[`ST_TOR_LSB + `ST_Q_STEP * i];
                end
                if (wr_c && sel_c == (i == 0 ? SEL_Q1 : SEL_Q2) && i_pwdata[`QC_ARM]) begin
                    arm_q[i] <= 1'b1;
                end
            end
            if (go_c) begin
                if (end_c) begin
                    cf_q[q_c] <= 1'b1;
                    st_q[q_c] <= Q_IDLE;
                    if (!cont_q[q_c]) begin
                        arm_q[q_c] <= 1'b0;
                    end
                end else begin
                    eng_q          <= ENG_CONV;
                    run_q          <= q_c;
                    cw_q           <= word_c;
                    cnt_q          <= 5'h00;
                    o_conv_start   <= 1'b1;
                    o_conv_channel <= word_c[5:0];
                    o_conv_phase   <= phase_of(word_c, 5'h00);
                end
            end else if (eng_q == ENG_CONV) begin
                if (run_q && abort2_c) begin
                    eng_q        <= ENG_IDLE;
                    o_conv_phase <= PH_NONE;
                end else if (done_c) begin
                    eng_q          <= ENG_IDLE;
                    o_conv_phase   <= PH_NONE;
                    ptr_q[run_q]   <= nptr_c;
                    if (cw_q[`CW_PAUSE]) begin
                        pf_q[run_q] <= 1'b1;
                    end
                    if (nend_c) begin
                        cf_q[run_q] <= 1'b1;
                        st_q[run_q] <= Q_IDLE;
                        if (!cont_q[run_q]) begin
                            arm_q[run_q] <= 1'b0;
                        end
                    end else if (cw_q[`CW_PAUSE]) begin
                        st_q[run_q] <= Q_PAUSED;
                    end
                end else if (tick_c) begin
                    cnt_q        <= cnt_q + 5'h01;
                    o_conv_phase <= phase_of(cw_q, cnt_q + 5'h01);
                end
            end
            // queue two waits while queue one runs
            if (!trig_c[0] && st_q[0] != Q_ACTIVE) begin
                if (st_q[1] == Q_PENDING) begin
                    st_q[1] <= Q_ACTIVE;
                end else if (st_q[1] == Q_SUSPENDED) begin
                    st_q[1] <= Q_ACTIVE;
                    if (!resume_q) begin
                        ptr_q[1] <= sub2_q;
                    end
                end
            end
            if (trig_c[0]) begin
                if (st_q[0] == Q_IDLE || st_q[0] == Q_PAUSED) begin
                    st_q[0] <= Q_ACTIVE;
                    if (st_q[0] == Q_IDLE) begin
                        ptr_q[0] <= 7'h00;
                    end
                end else begin
                    tor_q[0] <= 1'b1;
                end
                if (abort2_c) begin
                    st_q[1] <= Q_SUSPENDED;
                end
            end
            if (trig_c[1]) begin
                if (st_q[1] == Q_IDLE || st_q[1] == Q_PAUSED) begin
                    st_q[1] <= (st_q[0] == Q_ACTIVE || trig_c[0]) ? Q_PENDING
                                                                 : Q_ACTIVE;
                    if (st_q[1] == Q_IDLE) begin
                        ptr_q[1] <= q2_start_q;
                        sub2_q   <= q2_start_q;
                    end else begin
                        sub2_q   <= ptr_q[1];
                    end
                end else begin
                    tor_q[1] <= 1'b1;
                end
            end
        end
    end

    // checks
    sequence s_q1_runs;
        st_q[0] == Q_ACTIVE;
    endsequence

    sequence s_q2_fresh_trig;
        trig_c[1] && !trig_c[0] && st_q[1] == Q_IDLE;
    endsequence

    AST_Q2_PENDS: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        s_q1_runs and s_q2_fresh_trig |=> st_q[1] == Q_PENDING)
        else $error("queue two did not go pending behind queue one");

    AST_Q2_OVERRUN: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        trig_c[1] && (st_q[1] == Q_PENDING || st_q[1] == Q_SUSPENDED) |=> tor_q[1])
        else $error("queue two overrun not recorded");

    AST_Q2_SUSPEND: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        abort2_c |=> st_q[1] == Q_SUSPENDED && (eng_q == ENG_IDLE || !run_q))
        else $error("queue two not suspended by queue one trigger");

    AST_BOTH_TRIG: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        trig_c[0] && trig_c[1] && st_q[0] == Q_IDLE && st_q[1] == Q_IDLE
        |=> st_q[0] == Q_ACTIVE && st_q[1] == Q_PENDING)
        else $error("simultaneous triggers mishandled");

    AST_Q1_FIRST: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        go_c && !end_c && st_q[0] == Q_ACTIVE |=> eng_q == ENG_CONV && !run_q)
        else $error("queue one lost priority");

    AST_END_NO_CONV: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        go_c && end_c |=> !o_conv_start && cf_q[$past(q_c)] && eng_q == ENG_IDLE)
        else $error("end of queue converted or not flagged");

    AST_PAUSE_STATE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        done_c && cw_q[`CW_PAUSE] && !nend_c && !trig_c[run_q]
        |=> st_q[$past(run_q)] == Q_PAUSED && pf_q[$past(run_q)])
        else $error("pause word did not pause the queue");

    AST_LEN_BOUND: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        eng_q == ENG_CONV |-> cnt_q < conv_len(cw_q))
        else $error("conversion ran past its length");

    AST_BYPASS: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        o_conv_start && cw_q[`CW_BYP] |-> o_conv_phase != PH_BUFFERED)
        else $error("bypassed conversion used buffered sample");

    AST_RESULT_SLOT: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        done_c |=> res_mem[$past(ptr_c[5:0])] == $past(i_conv_result))
        else $error("result stored at wrong entry");

endmodule

// [testbench/adc_queue_sequencer_bench.sv]
// self-checking bench for the two-queue command word sequencer
// assumes: design and package compiled first; bench drives apb, pins and converter result
`timescale 1ns/1ns

module adc_queue_sequencer_bench;
    import qseq_pkg::*;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic        pready, pslverr, rerr, trig_one = 0, trig_two = 0, conv_start;
    logic [5:0]  conv_ch;
    phase_t      conv_phase;
    logic [9:0]  conv_res = '0;
    logic [9:0]  cw [7] = '{10'h0C5, 10'h206, 10'h207, 10'h03F, 10'h109, 10'h00A, 10'h03F};
    int          fails = 0, samples_checked = 0, cycles = 0, starts = 0, n0;

    adc_queue_sequencer i_dut (.i_clk_sys(clk), .i_reset(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_ext_trig_one(trig_one), .i_ext_trig_two(trig_two), .o_conv_start(conv_start),
        .o_conv_channel(conv_ch), .o_conv_phase(conv_phase), .i_conv_result(conv_res));

    initial forever #20 clk = ~clk;

    // converter core answers with a channel-derived code
    always @(posedge clk) begin
        conv_res <= {4'hA, conv_ch};
        if (conv_start === 1'b1) begin
            starts++;
            // channel 9 word is bypassed: starts in final sample
            chk("start phase", (conv_ch == 6'h09) ? 32'h0000_0002 : 32'h0000_0001,
                32'(conv_phase));
        end
        cycles++;
        if (cycles == 30000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_flag(input int b);
        int n;
        n = 0;
        do begin
            apb(0, 12'h00C, 0);
            n++;
        end while (rdat[b] !== 1'b1 && n < 400);
    endtask

    function automatic logic [31:0] res(input logic [5:0] ch);
        return {22'h0, 4'hA, ch};
    endfunction

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(0, 12'h000, 0);
        chk("ctrl0 reset", 32'h0000_0B40, rdat);
        apb(0, 12'h300, 0);
        chk("unmapped err", 1, rerr);
        apb(1, 12'h000, 32'h0000_0004);
        for (int i = 0; i < 7; i++) apb(1, 12'h100 + 12'(4 * i), {22'h0, cw[i]});
        apb(1, 12'h004, 32'h0000_0011);
        wait_flag(9);
        chk("q1 paused", 32'h0000_0202, rdat & 32'h0000_7777);
        apb(1, 12'h00C, 32'h0000_7700);
        apb(1, 12'h004, 32'h0000_0011);
        wait_flag(8);
        chk("q1 pause then end", 32'h0000_0300, rdat & 32'h0000_7777);
        for (int i = 0; i < 3; i++) begin
            apb(0, 12'h200 + 12'(4 * i), 0);
            chk("q1 result", res(cw[i][5:0]), rdat);
        end
        apb(1, 12'h00C, 32'h0000_7700);
        apb(1, 12'h004, 32'h0000_0012);
        apb(1, 12'h008, 32'h0000_0012);
        trig_one <= 1'b1;
        trig_two <= 1'b1;
        repeat (8) @(posedge clk);
        apb(0, 12'h00C, 0);
        chk("simultaneous", 32'h0000_0031, rdat & 32'h0000_7777);
        trig_two <= 1'b0;
        repeat (4) @(posedge clk);
        trig_two <= 1'b1;
        repeat (8) @(posedge clk);
        apb(0, 12'h00C, 0);
        chk("q2 overrun", 1, rdat[14]);
        wait_flag(12);
        chk("q2 done", 32'h0000_0000, rdat & 32'h0000_0070);
        for (int i = 4; i < 6; i++) begin
            apb(0, 12'h200 + 12'(4 * i), 0);
            chk("q2 result", res(cw[i][5:0]), rdat);
        end
        apb(1, 12'h000, 32'h0000_0040);
        apb(1, 12'h00C, 32'h0000_7700);
        n0 = starts;
        apb(1, 12'h008, 32'h0000_0011);
        wait_flag(12);
        chk("q2 beyond table idle", 32'h0000_0000, rdat & 32'h0000_0070);
        chk("q2 beyond table starts", n0, starts);
        wrap_up();
    end
endmodule
